// [design/swl_dev.sv]
// Purpose: Device end of the single-wire configuration link, bit and frame layer
// Assumes: LINK_CLK free-running; user side on CLK; wire reached through swl_if
// Notes:   Received frames cross to CLK by toggle; response frames cross back likewise
`timescale 1ns/10ps
module swl_dev #(
  parameter int CW       = 16,
  parameter int TRES_CYC = swl_pkg::TRES_LCYC
) (
  input  wire logic        LINK_CLK,      // Link-side clock
  input  wire logic        CLK,           // User-side clock
  input  wire logic        RESETN,        // Async reset, active low
  swl_if.dev               LINK,          // Single wire
  output logic             RX_VALID,      // Pulse: new frame in RX_WORD
  output logic [17:0]      RX_WORD,       // Last received frame
  output logic             RX_PARITY_OK,  // Frame has odd parity
  input  wire logic        TX_LOAD,       // Pulse: take TX_WORD
  input  wire logic [17:0] TX_WORD        // Next response frame
);
  localparam int FB = swl_pkg::FRAME_BITS;
  localparam int QW = $clog2(TRES_CYC + 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10,
    ST_RESP = 2'b11
  } swl_dst_t;
  // ==========================================================================
  // Wire edges on the link clock
  logic          line_s;
  logic          line_q;
  logic          fall;
  logic          rise;
  swl_sync #(.RST_VAL(1'b1)) u_line (
    .clk   (LINK_CLK),
    .rst_n (RESETN),
    .d     (LINK.line),
    .q     (line_s)
  );
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
      line_q <= 1'b1;
    else
      line_q <= line_s;
  end
  assign fall = line_q & ~line_s;
  assign rise = ~line_q & line_s;
  // ==========================================================================
  // Phase timing
  swl_dst_t      state_q;
  logic [CW-1:0] low_q;
  logic [CW-1:0] high_q;
  logic [CW:0]   period;
  logic [CW-1:0] diff;
  logic          bit_val;
  logic          period_ok;
  logic          too_long;
  logic          accept;
  logic          reject;
  logic          timeout;
  logic [QW-1:0] quiet_q;
  logic [4:0]    bit_cnt_q;
  assign period    = {1'b0, low_q} + {1'b0, high_q};
  assign period_ok = (period >= (CW+1)'(swl_pkg::T_MIN_LCYC)) &&
                     (period <= (CW+1)'(swl_pkg::T_MAX_LCYC));
  assign too_long  = (state_q == ST_LOW || state_q == ST_HIGH) &&
                     (period > (CW+1)'(swl_pkg::T_MAX_LCYC));
  assign bit_val   = low_q > high_q;
  assign diff      = bit_val ? (low_q - high_q) : (high_q - low_q);
  assign accept    = (state_q == ST_HIGH) && fall && period_ok;
  assign reject    = ((state_q == ST_HIGH) && fall && !period_ok) || too_long;
  assign timeout   = quiet_q == QW'(TRES_CYC - 1);
  // Low runs from falling to rising edge, high from rising to the opening pulse
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      low_q  <= '0;
      high_q <= '0;
    end
    else if (state_q == ST_LOW)
    begin
      low_q  <= low_q + 1'b1;
      high_q <= '0;
    end
    else if (state_q == ST_HIGH)
      high_q <= high_q + 1'b1;
    else if (state_q == ST_IDLE)
      low_q  <= '0;
  end
  // ==========================================================================
  // Bit sequencer
  logic [CW:0]   win_q;
  logic [CW-1:0] drv_q;
  logic          dev_oe_q;
  logic          tx_bit;
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
      state_q <= ST_IDLE;
    else if (timeout || reject)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE: if (fall) state_q <= ST_LOW;
        ST_LOW:  if (rise) state_q <= ST_HIGH;
        ST_HIGH: if (accept) state_q <= ST_RESP;
        ST_RESP: if (win_q <= (CW+1)'(1)) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Our own pull during the window would look like a new bit, so edges are
  // ignored until the window has run out
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      win_q    <= '0;
      drv_q    <= '0;
      dev_oe_q <= 1'b0;
    end
    else if (accept)
    begin
      win_q    <= {diff, 1'b0};
      drv_q    <= diff;
      dev_oe_q <= tx_bit;
    end
    else if (state_q == ST_RESP)
    begin
      win_q <= win_q - 1'b1;
      if (drv_q != '0)
        drv_q <= drv_q - 1'b1;
      if (drv_q <= CW'(1))
        dev_oe_q <= 1'b0;
    end
    else
      dev_oe_q <= 1'b0;
  end
  assign LINK.dev_o  = 1'b0;
  assign LINK.dev_oe = dev_oe_q;
  // Silence since the last accepted bit; cleared once nothing is pending
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
      quiet_q <= '0;
    else if (accept || timeout || (state_q == ST_IDLE && bit_cnt_q == '0))
      quiet_q <= '0;
    else
      quiet_q <= quiet_q + 1'b1;
  end

  // ==========================================================================
  // Frame assembly on the link side
  logic [FB-1:0] rx_sh_q;
  logic [FB-1:0] rx_next;
  logic [FB-1:0] rx_word_q;
  logic          rx_tgl_q;
  logic [FB-1:0] tx_sh_q;
  logic [FB-1:0] tx_eff;
  logic [FB-1:0] tx_link_q;
  logic          tx_tgl_s;
  logic          tx_seen_q;
  logic [FB-1:0] tx_cap_q;
  logic          tx_tgl_q;
  assign rx_next = {rx_sh_q[FB-2:0], bit_val};
  assign tx_eff  = (bit_cnt_q == '0) ? tx_link_q : tx_sh_q;
  assign tx_bit  = tx_eff[FB-1];

  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      bit_cnt_q <= '0;
      rx_sh_q   <= '0;
      rx_word_q <= '0;
      rx_tgl_q  <= 1'b0;
      tx_sh_q   <= '0;
    end
    else if (timeout || reject)
      bit_cnt_q <= '0;
    else if (accept)
    begin
      rx_sh_q <= rx_next;
      tx_sh_q <= {tx_eff[FB-2:0], 1'b0};
      if (bit_cnt_q == 5'(FB - 1))
      begin
        bit_cnt_q <= '0;
        rx_word_q <= rx_next;
        rx_tgl_q  <= ~rx_tgl_q;
      end
      else
        bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end
  // Response word taken over from the user side by toggle
  swl_sync u_tx_tgl (
    .clk   (LINK_CLK),
    .rst_n (RESETN),
    .d     (tx_tgl_q),
    .q     (tx_tgl_s)
  );

  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_seen_q <= 1'b0;
      tx_link_q <= '0;
    end
    else if (tx_tgl_s != tx_seen_q)
    begin
      tx_seen_q <= tx_tgl_s;
      tx_link_q <= tx_cap_q;
    end
  end
  // ==========================================================================
  // User side on CLK
  logic rx_tgl_s;
  logic rx_seen_q;
  // Captured word must stay put until the link side has copied it
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_cap_q <= '0;
      tx_tgl_q <= 1'b0;
    end
    else if (TX_LOAD)
    begin
      tx_cap_q <= TX_WORD;
      tx_tgl_q <= ~tx_tgl_q;
    end
  end
  swl_sync u_rx_tgl (
    .clk   (CLK),
    .rst_n (RESETN),
    .d     (rx_tgl_q),
    .q     (rx_tgl_s)
  );

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_seen_q    <= 1'b0;
      RX_VALID     <= 1'b0;
      RX_WORD      <= '0;
      RX_PARITY_OK <= 1'b0;
    end
    else
    begin
      RX_VALID <= 1'b0;
      if (rx_tgl_s != rx_seen_q)
      begin
        rx_seen_q    <= rx_tgl_s;
        RX_VALID     <= 1'b1;
        RX_WORD      <= rx_word_q;
        RX_PARITY_OK <= ^rx_word_q;
      end
    end
  end
endmodule

// [design/swl_pkg.sv]
// Purpose: Shared constants of the single-wire configuration link bit layer
// Assumes: Device link logic on an 80 ns link clock, programmer logic on a 5 ns clock
// Notes:   Times are kept in their own unit, cycle counts are derived from them
package swl_pkg;

  // ==========================================================================
  // Clocks
  localparam int CLK_NS  = 5;
  localparam int LCLK_NS = 80;

  // ==========================================================================
  // Bit period window and interface reset time
  localparam int T_MIN_NS    = 40000;
  localparam int T_MAX_NS    = 120000;
  localparam int TRES_MIN_NS = 1700000;
  localparam int TRES_MAX_NS = 5000000;
  // Least times round up, longest times round down
  localparam int T_MIN_LCYC  = (T_MIN_NS + LCLK_NS - 1) / LCLK_NS;
  localparam int T_MAX_LCYC  = T_MAX_NS / LCLK_NS;
  localparam int TRES_LCYC   = (TRES_MIN_NS + LCLK_NS - 1) / LCLK_NS;

  // ==========================================================================
  // Frame layout: control bit, 16 data bits MSB first, odd parity bit
  localparam int FRAME_BITS = 18;
  localparam int DATA_BITS  = 16;

  // ==========================================================================
  // Programmer bit shaping, in percent of T or of the response window
  localparam int PROG_T_NS     = 60000;
  localparam int PROG_T_CYC    = PROG_T_NS / CLK_NS;
  localparam int PROG_GAP_NS   = 200000;
  localparam int PROG_GAP_CYC  = PROG_GAP_NS / CLK_NS;
  localparam int ZERO_LOW_PCT  = 33;
  localparam int ONE_LOW_PCT   = 67;
  localparam int OPEN_PCT      = 20;
  localparam int SAMPLE_PCT    = 35;
  localparam int PAUSE_PCT     = 10;

endpackage

// [design/swl_if.sv]
// Purpose: Open-drain single wire shared by programmer and device
// Assumes: External pull-up; each end only pulls low
// Notes:   The wire level is resolved here from both output enables
`timescale 1ns/10ps
interface swl_if;
  logic prog_o;   // Programmer output level
  logic prog_oe;  // Programmer drives the wire
  logic dev_o;    // Device output level
  logic dev_oe;   // Device drives the wire
  logic line;     // Resolved wire level

  // Pull-up wins unless an enabled driver pulls low
  assign line = ~((prog_oe & ~prog_o) | (dev_oe & ~dev_o));

  modport dev  (input line, output dev_o, output dev_oe);
  modport prog (input line, output prog_o, output prog_oe);
endinterface

// [design/swl_sync.sv]
// Purpose: Three-stage synchroniser for pins and cross-domain levels
// Assumes: Input is asynchronous to clk
// Notes:   Output follows only when the second and third stages agree
`timescale 1ns/10ps
module swl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,    // Sampling clock
  input  wire logic rst_n,  // Async reset, active low
  input  wire logic d,      // Asynchronous input
  output logic      q       // Filtered synchronous level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q    <= RST_VAL;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q <= s3_q;
    end
  end
endmodule

// [design/swl_prog.sv]
// Purpose: Programmer end of the single-wire configuration link, bit and frame layer
// Assumes: Runs on CLK only; the wire is sampled through the three-stage synchroniser
// Notes:   Sends one 18-bit frame per request and returns the 18 response bits
`timescale 1ns/10ps
module swl_prog #(
  parameter int CW      = 17,
  parameter int T_CYC   = swl_pkg::PROG_T_CYC,
  parameter int GAP_CYC = swl_pkg::PROG_GAP_CYC
) (
  input  wire logic        CLK,        // Clock
  input  wire logic        RESETN,     // Async reset, active low
  swl_if.prog              LINK,       // Single wire
  input  wire logic        CMD_VALID,  // Request to send CMD_WORD
  input  wire logic [17:0] CMD_WORD,   // Frame to send, sent MSB first
  output logic             CMD_READY,  // Idle, request taken when valid
  output logic             RSP_VALID,  // Pulse: RSP_WORD holds the answer
  output logic [17:0]      RSP_WORD    // Response bits, first one in bit 17
);
  localparam int FB     = swl_pkg::FRAME_BITS;
  localparam int Z_LOW  = T_CYC * swl_pkg::ZERO_LOW_PCT / 100;
  localparam int O_LOW  = T_CYC * swl_pkg::ONE_LOW_PCT / 100;
  localparam int Z_WIN  = 2 * (T_CYC - 2 * Z_LOW);
  localparam int O_WIN  = 2 * (2 * O_LOW - T_CYC);
  localparam int Z_OPEN = Z_WIN * swl_pkg::OPEN_PCT / 100;
  localparam int O_OPEN = O_WIN * swl_pkg::OPEN_PCT / 100;
  localparam int Z_SAMP = Z_WIN * swl_pkg::SAMPLE_PCT / 100;
  localparam int O_SAMP = O_WIN * swl_pkg::SAMPLE_PCT / 100;
  localparam int Z_PAUSE = Z_WIN * swl_pkg::PAUSE_PCT / 100;
  localparam int O_PAUSE = O_WIN * swl_pkg::PAUSE_PCT / 100;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_LOW  = 3'b001,
    P_HIGH = 3'b010,
    P_OPEN = 3'b011,
    P_WIN  = 3'b100,
    P_GAP  = 3'b101
  } swl_pst_t;

  // ==========================================================================
  // Per-bit timing
  swl_pst_t      state_q;
  logic [CW-1:0] cnt_q;
  logic [FB-1:0] sh_q;
  logic [FB-1:0] rsp_sh_q;
  logic [4:0]    left_q;
  logic          oe_q;
  logic          line_s;
  logic [CW-1:0] low_len;
  logic [CW-1:0] high_len;
  logic [CW-1:0] open_len;
  logic [CW-1:0] win_len;
  logic [CW-1:0] samp_at;
  logic [CW-1:0] pause_len;

  assign low_len  = sh_q[FB-1] ? CW'(O_LOW) : CW'(Z_LOW);
  assign high_len = CW'(T_CYC) - low_len;
  assign win_len  = sh_q[FB-1] ? CW'(O_WIN) : CW'(Z_WIN);
  assign open_len = sh_q[FB-1] ? CW'(O_OPEN) : CW'(Z_OPEN);
  assign samp_at  = sh_q[FB-1] ? CW'(O_SAMP) : CW'(Z_SAMP);
  // The device sees our edges a few of its cycles late and measures the
  // window with an error, so the next bit waits a little past the window
  assign pause_len = sh_q[FB-1] ? CW'(O_PAUSE) : CW'(Z_PAUSE);

  swl_sync #(.RST_VAL(1'b1)) u_line (
    .clk   (CLK),
    .rst_n (RESETN),
    .d     (LINK.line),
    .q     (line_s)
  );

  // ==========================================================================
  // Sequencer; the counter runs on through the opening pulse into the window
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q  <= P_IDLE;
      cnt_q    <= '0;
      sh_q     <= '0;
      left_q   <= '0;
      oe_q     <= 1'b0;
      rsp_sh_q <= '0;
      RSP_VALID <= 1'b0;
      RSP_WORD  <= '0;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      cnt_q     <= cnt_q + 1'b1;
      case (state_q)
        P_IDLE:
        begin
          cnt_q <= '0;
          if (CMD_VALID)
          begin
            sh_q    <= CMD_WORD;
            left_q  <= 5'(FB);
            oe_q    <= 1'b1;
            state_q <= P_LOW;
          end
        end
        P_LOW:
          if (cnt_q == low_len - 1'b1)
          begin
            cnt_q   <= '0;
            oe_q    <= 1'b0;
            state_q <= P_HIGH;
          end
        P_HIGH:
          if (cnt_q == high_len - 1'b1)
          begin
            cnt_q   <= '0;
            oe_q    <= 1'b1;
            state_q <= P_OPEN;
          end
        P_OPEN:
          if (cnt_q == open_len - 1'b1)
          begin
            oe_q    <= 1'b0;
            state_q <= P_WIN;
          end
        P_WIN:
        begin
          if (cnt_q == samp_at)
            rsp_sh_q <= {rsp_sh_q[FB-2:0], ~line_s};
          if (cnt_q == win_len + pause_len - 1'b1)
          begin
            cnt_q  <= '0;
            left_q <= left_q - 1'b1;
            if (left_q > 5'd1)
            begin
              sh_q    <= {sh_q[FB-2:0], 1'b0};
              oe_q    <= 1'b1;
              state_q <= P_LOW;
            end
            else
            begin
              RSP_VALID <= 1'b1;
              RSP_WORD  <= rsp_sh_q;
              state_q   <= P_GAP;
            end
          end
        end
        P_GAP:
          if (cnt_q == CW'(GAP_CYC - 1))
            state_q <= P_IDLE;
        default: state_q <= P_IDLE;
      endcase
    end
  end

  assign CMD_READY    = state_q == P_IDLE;
  assign LINK.prog_o  = 1'b0;
  assign LINK.prog_oe = oe_q;
endmodule

// [verif/swl_link_asserts.sv]
// Purpose: Assertions on the wire that joins programmer and device
// Assumes: Signals of the first link interface; both ends are design code
// Notes:   Lengths come from async samples, so a few link cycles of slack are allowed
`timescale 1ns/10ps
module swl_link_asserts #(
  parameter int T_CYC = swl_pkg::PROG_T_CYC
) (
  input wire logic CLK,       // Programmer clock
  input wire logic LINK_CLK,  // Device clock
  input wire logic RESETN,    // Async reset, active low
  input wire logic prog_o,    // Programmer level
  input wire logic prog_oe,   // Programmer pulls low
  input wire logic dev_o,     // Device level
  input wire logic dev_oe,    // Device pulls low
  input wire logic line       // Resolved wire
);
  // ==========================================================================
  // Phase lengths
  logic        prog_q;
  logic [15:0] run_q, hi_q, lo_q, pon_q, diff_q, dh_q, since_q;
  int          prun_q;

  always_ff @(posedge LINK_CLK or negedge RESETN)
    if (!RESETN)
    begin
      prog_q <= 1'b0;
      run_q  <= 16'h0;
      hi_q   <= 16'h0;
      lo_q   <= 16'h0;
      pon_q  <= 16'hff;
    end
    else
    begin
      prog_q <= prog_oe;
      run_q  <= (prog_oe != prog_q) ? 16'h1 : run_q + 16'h1;
      pon_q  <= (prog_oe && !prog_q) ? 16'h0 : (pon_q == 16'hff ? pon_q : pon_q + 16'h1);
      if (prog_q && !prog_oe) hi_q <= run_q;
      if (!prog_q && prog_oe) lo_q <= run_q;
    end

  // Saturating gap so the first response after reset always passes
  always_ff @(posedge LINK_CLK or negedge RESETN)
    if (!RESETN)
    begin
      diff_q  <= 16'h0;
      dh_q    <= 16'h0;
      since_q <= 16'hffff;
    end
    else
    begin
      if ($rose(dev_oe)) diff_q <= (hi_q > lo_q) ? hi_q - lo_q : lo_q - hi_q;
      dh_q    <= dev_oe ? dh_q + 16'h1 : 16'h0;
      since_q <= $rose(dev_oe) ? 16'h1 : (&since_q ? since_q : since_q + 16'h1);
    end

  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN) prun_q <= 0;
    else prun_q <= prog_oe ? prun_q + 1 : 0;

  function automatic bit in_pm(input int n, input int lo, input int hi);
    return n * 1000 >= lo * T_CYC && n * 1000 <= hi * T_CYC;
  endfunction

  // ==========================================================================
  // Properties
  sequence s_resp_rise;
    $rose(dev_oe);
  endsequence
  sequence s_resp_hold;
    dev_oe [*8];
  endsequence

  chk_dev_pulls_low: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    dev_oe |-> !dev_o && !line) else $error("device drives the wire high");
  chk_prog_pulls_low: assert property (@(posedge CLK) disable iff (!RESETN)
    prog_oe |-> !prog_o) else $error("programmer drives the wire high");
  chk_resp_after_open: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_resp_rise |-> prog_oe && pon_q <= 16'ha) else $error("response not after opening pulse");
  chk_resp_held: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_resp_rise |-> s_resp_hold) else $error("response pulse too short");
  chk_resp_length: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    $fell(dev_oe) |-> dh_q + 16'h4 >= diff_q && dh_q <= diff_q + 16'h4)
    else $error("response length differs from low-high difference");
  chk_free_before_bit: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    $rose(prog_oe) |-> !dev_oe) else $error("device still drives at next bit");
  chk_resp_spacing: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_resp_rise |-> since_q >= 16'(swl_pkg::T_MIN_LCYC)) else $error("responses too close");
  chk_prog_shape: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(prog_oe) |-> in_pm(prun_q, 280, 380) || in_pm(prun_q, 620, 720)
    || in_pm(prun_q, 48, 264)) else $error("programmer low pulse out of range");
endmodule

// [verif/pwm_bit_sync_single_wire_link_test.sv]
// Purpose: Self-checking bench for programmer and device ends of the link
// Assumes: Bit period near the shortest accepted one; device time-out shortened
// Notes:   A frame spans 18 periods of at least 40 us, so the run is long;
//          a bench driver on a second wire breaks the timing on purpose
`timescale 1ns/10ps
module pwm_bit_sync_single_wire_link_test;
  localparam int T_CYC    = 8400;  // 42 us
  localparam int TRES_CYC = 1400;  // Must exceed the spacing of bits

  logic        clk, link_clk, rst_n;
  logic        cmd_valid = 1'b0, tx_load = 1'b0;
  logic        cmd_ready, rsp_valid, rx_valid, rx_ok, rx_valid_2, rx_ok_2;
  logic [17:0] cmd_word = 18'h0, tx_word = 18'h0;
  logic [17:0] rsp_word, rx_word, rx_word_2;
  logic [31:0] lfsr_q = 32'h5e64c43f;
  logic [18:0] e_rx[$], e_rsp[$], e_rx2[$];
  int          mismatches = 0, checks = 0;

  swl_if u_link();
  swl_if u_link2();

  swl_prog #(.T_CYC(T_CYC)) i_swl_prog (.CLK(clk), .RESETN(rst_n), .LINK(u_link),
    .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_WORD(rsp_word));
  swl_dev #(.TRES_CYC(TRES_CYC)) i_swl_dev (.LINK_CLK(link_clk), .CLK(clk), .RESETN(rst_n),
    .LINK(u_link), .RX_VALID(rx_valid), .RX_WORD(rx_word), .RX_PARITY_OK(rx_ok),
    .TX_LOAD(tx_load), .TX_WORD(tx_word));
  swl_dev #(.TRES_CYC(TRES_CYC)) i_swl_dev_2 (.LINK_CLK(link_clk), .CLK(clk), .RESETN(rst_n),
    .LINK(u_link2), .RX_VALID(rx_valid_2), .RX_WORD(rx_word_2), .RX_PARITY_OK(rx_ok_2),
    .TX_LOAD(tx_load), .TX_WORD(18'h3ffff));
  swl_link_asserts #(.T_CYC(T_CYC)) i_swl_link_asserts (.CLK(clk), .LINK_CLK(link_clk),
    .RESETN(rst_n), .prog_o(u_link.prog_o), .prog_oe(u_link.prog_oe),
    .dev_o(u_link.dev_o), .dev_oe(u_link.dev_oe), .line(u_link.line));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict;
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic bail;
    mismatches++;
    give_verdict();
  endtask

  task automatic compare(input logic [18:0] got, input logic [18:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bit on the second wire, answer sampled at 0.35 of the window
  task automatic drive_bit(input logic v, input int t, input logic exp);
    int low;
    int diff;
    low = v ? t * 67 / 100 : t * 33 / 100;
    diff = (2 * low > t) ? 2 * low - t : t - 2 * low;
    u_link2.prog_oe <= 1'b1;
    repeat (low) @(posedge clk);
    u_link2.prog_oe <= 1'b0;
    repeat (t - low) @(posedge clk);
    u_link2.prog_oe <= 1'b1;
    repeat (diff * 2 / 5) @(posedge clk);
    u_link2.prog_oe <= 1'b0;
    repeat (diff * 7 / 10 - diff * 2 / 5) @(posedge clk);
    compare({18'h0, u_link2.line}, {18'h0, exp});
    // The device ends its window a few link cycles late; wait that out
    repeat (2 * diff - diff * 7 / 10 + diff / 5) @(posedge clk);
  endtask

  task automatic run_frame;
    int n;
    lfsr_q = lfsr_next(lfsr_next(lfsr_q));
    tx_load <= 1'b1;
    tx_word <= lfsr_q[31:14];
    e_rsp.push_back({1'b0, lfsr_q[31:14]});
    @(posedge clk);
    tx_load <= 1'b0;
    // Let the device's wire filter settle before the first bit
    repeat (64) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= lfsr_q[17:0];
    e_rx.push_back({lfsr_q[17:0], ^lfsr_q[17:0]});
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    if (n == 100) bail();
  endtask

  task automatic run_driver;
    logic [17:0] w;
    repeat (200) @(posedge clk);
    w = lfsr_q[24:7];
    for (int i = 0; i < 5; i++) drive_bit(1'b0, T_CYC, 1'b0);
    drive_bit(1'b1, 4000, 1'b1);
    for (int i = 0; i < 3; i++) drive_bit(1'b1, T_CYC, 1'b0);
    repeat (TRES_CYC * 20) @(posedge clk);
    e_rx2.push_back({w, ^w});
    for (int i = 17; i >= 0; i--) drive_bit(w[i], T_CYC, 1'b0);
  endtask

  // ==========================================================================
  // Clocks, results and sequence
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #17.3;
    forever #40 link_clk = ~link_clk;
  end

  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      compare({rx_word, rx_ok}, e_rx.size() > 0 ? e_rx.pop_front() : 'x);
    if (rsp_valid === 1'b1)
      compare({1'b0, rsp_word}, e_rsp.size() > 0 ? e_rsp.pop_front() : 'x);
    if (rx_valid_2 === 1'b1)
      compare({rx_word_2, rx_ok_2}, e_rx2.size() > 0 ? e_rx2.pop_front() : 'x);
  end

  initial
  begin
    int n;
    u_link2.prog_o = 1'b0;
    u_link2.prog_oe = 1'b0;
    // Scheduled so every asynchronous reset sees a falling edge at time zero
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    fork
      run_frame();
      run_driver();
    join
    n = 0;
    while (e_rx.size() + e_rsp.size() + e_rx2.size() > 0 && n < 300000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 300000) bail();
    give_verdict();
  end
endmodule
